// ==== inc/fp_pkg.sv ====
/*
  Shared constants of the front-panel clear and secure control block.
  Assumes a 50 MHz controller clock; long counts are overridable at the top.
*/
package fp_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 50;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_S = 4;
  localparam int unsigned HOLD_CYCLES = HOLD_S * CLK_HZ;
  localparam int unsigned BEEP_MS = 100;
  localparam int unsigned BEEP_CYCLES = BEEP_MS * (CLK_HZ / 1000);
  // button index
  localparam int BTN_POWER = 0;
  localparam int BTN_SLEEP = 1;
  localparam int BTN_RESET = 2;
  localparam int BTN_DIAG = 3;
  localparam int BTN_IDENT = 4;
  localparam int BTN_COUNT = 5;
  // sleep state encoding
  localparam logic [1:0] SLEEP_S0 = 2'h0;
  localparam logic [1:0] SLEEP_S1 = 2'h1;
  localparam logic [1:0] SLEEP_S45 = 2'h3;
  // fault types and sources
  localparam int FAULT_FAN = 0;
  localparam int FAULT_TEMP = 1;
  localparam int FAULT_PWR = 2;
  localparam int FAULT_DRIVE = 3;
  localparam int FAULT_TYPES = 4;
  localparam int FAULT_SOURCES = 16;
  localparam logic [7:0] VIOLATION_OFFSET = 8'h00;
  localparam logic CLR_SEQ_EN_RST = 1'b1;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_HOLD = 2'h1,
    SEQ_ARMED = 2'h3,
    SEQ_RELEASE = 2'h2
  } seq_state_e;
endpackage : fp_pkg

// ==== test/front_panel_clear_and_secure_ctrl_bench.sv ====
/*
  Self-checking bench for the front-panel clear, secure and fault block.
  Assumes short counts set by parameter; the partner model drives buttons and clear commands.
*/
`timescale 1ns/1ps
module front_panel_clear_and_secure_ctrl_bench;
  localparam int DEB = 4;
  localparam int HOLD = 20;
  localparam int BEEP = 5;
  logic clk, rst_n, cmdReq, cmdEnable, cmdForceOn, cmdForceOff;
  logic [4:0] pressReq, btnN;
  logic clrOptValid, clrOptEnable, clrOptForceOn, clrOptForceOff;
  logic standbyPwr, sysPwrOn, sysResetIn, kbcLockRequest;
  logic [1:0] sleepState;
  logic secOptValid, secOptEnable, secOptForceOn;
  logic [4:0] secOptLockMask;
  logic faultValid, faultState;
  logic [3:0] faultSource, platformFault, faultLeds;
  logic [1:0] faultType;
  logic clearMemOut, beepOut, powerUpReq, clearSeqEnabled, secureActive;
  logic [4:0] btnPressOut;
  logic powerOverrideOut, violationEvt, fanBoost, beepPrev;
  logic [7:0] violationOffset;
  int mismatches = 0;
  int n_tests = 0;
  int nViol, nOvr, nUp, nBeepRise, nBeepCyc;
  int nPress [5];
  logic [1:0] states [3] = '{fp_pkg::SLEEP_S0, fp_pkg::SLEEP_S1, fp_pkg::SLEEP_S45};
  logic [4:0] prot [3] = '{5'h07, 5'h04, 5'h00};

  panel_host_model panel_host_model_i (.clk(clk), .rst_n(rst_n), .pressReq(pressReq),
    .cmdReq(cmdReq), .cmdEnable(cmdEnable), .cmdForceOn(cmdForceOn),
    .cmdForceOff(cmdForceOff), .sysPwrOn(sysPwrOn), .btnN(btnN),
    .clrOptValid(clrOptValid), .clrOptEnable(clrOptEnable),
    .clrOptForceOn(clrOptForceOn), .clrOptForceOff(clrOptForceOff));

  front_panel_clear_and_secure_ctrl #(.DEBOUNCE_CYC(DEB), .HOLD_CYC(HOLD), .BEEP_CYC(BEEP))
  front_panel_clear_and_secure_ctrl_i (.clk(clk), .rst_n(rst_n), .powerBtnN(btnN[0]),
    .sleepBtnN(btnN[1]), .resetBtnN(btnN[2]), .diagBtnN(btnN[3]), .identBtnN(btnN[4]),
    .standbyPwr(standbyPwr), .sysPwrOn(sysPwrOn), .sysResetIn(sysResetIn),
    .sleepState(sleepState), .kbcLockRequest(kbcLockRequest), .clrOptValid(clrOptValid),
    .clrOptEnable(clrOptEnable), .clrOptForceOn(clrOptForceOn),
    .clrOptForceOff(clrOptForceOff), .secOptValid(secOptValid), .secOptEnable(secOptEnable),
    .secOptForceOn(secOptForceOn), .secOptLockMask(secOptLockMask), .faultValid(faultValid),
    .faultSource(faultSource), .faultType(faultType), .faultState(faultState),
    .platformFault(platformFault), .clearMemOut(clearMemOut), .beepOut(beepOut),
    .powerUpReq(powerUpReq), .clearSeqEnabled(clearSeqEnabled), .secureActive(secureActive),
    .btnPressOut(btnPressOut), .powerOverrideOut(powerOverrideOut),
    .violationEvt(violationEvt), .violationOffset(violationOffset), .faultLeds(faultLeds),
    .fanBoost(fanBoost));

  always #10 clk = ~clk;

  // event counters sampled on the edge, so a one-cycle pulse is never missed
  always @(posedge clk) begin
    beepPrev <= beepOut;
    if (violationEvt === 1'b1) nViol++;
    if (powerOverrideOut === 1'b1) nOvr++;
    if (powerUpReq === 1'b1) nUp++;
    if (beepOut === 1'b1) nBeepCyc++;
    if (beepOut === 1'b1 && beepPrev !== 1'b1) nBeepRise++;
    for (int i = 0; i < 5; i++) begin
      if (btnPressOut[i] === 1'b1) nPress[i]++;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic zero();
    nViol = 0; nOvr = 0; nUp = 0; nBeepRise = 0; nBeepCyc = 0;
    for (int i = 0; i < 5; i++) nPress[i] = 0;
  endtask : zero

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_vec

  task automatic check_cnt(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_cnt

  task automatic press(input int b, input int hold);
    pressReq[b] = 1'b1;
    tick(hold);
    pressReq[b] = 1'b0;
    tick(DEB + 4);
  endtask : press

  task automatic clr_cmd(input logic en, input logic on, input logic off);
    cmdEnable = en; cmdForceOn = on; cmdForceOff = off; cmdReq = 1'b1;
    tick(1);
    cmdReq = 1'b0;
    tick(4);
  endtask : clr_cmd

  task automatic sec_cfg(input logic en, input logic on, input logic [4:0] lock);
    secOptEnable = en; secOptForceOn = on; secOptLockMask = lock; secOptValid = 1'b1;
    tick(1);
    secOptValid = 1'b0;
    secOptEnable = ~en; secOptForceOn = ~on; secOptLockMask = ~lock;
    tick(3);
  endtask : sec_cfg

  task automatic rpt(input logic [3:0] src, input logic [1:0] typ, input logic st);
    faultSource = src; faultType = typ; faultState = st; faultValid = 1'b1;
    tick(1);
    faultValid = 1'b0;
    faultSource = ~src; faultType = ~typ; faultState = ~st;
    tick(3);
  endtask : rpt

  task automatic sys_reset();
    sysResetIn = 1'b1;
    tick(4);
    sysResetIn = 1'b0;
    tick(4);
  endtask : sys_reset

  // reset held for the given number of cycles, power pressed, then both released
  task automatic run_seq(input int hold);
    zero();
    pressReq[2] = 1'b1;
    tick(hold);
    pressReq[0] = 1'b1;
    tick(DEB + 4);
    pressReq = 5'h00;
    tick(DEB + 6);
  endtask : run_seq

  task automatic t_clear_seq();
    press(2, DEB + HOLD - 2);
    run_seq(HOLD - 2);
    check_cnt("upShortHold", 0, nUp);
    check_bit("clrShortHold", 1'b0, clearMemOut);
    run_seq(DEB + HOLD + 6);
    check_bit("clrMemSeq", 1'b1, clearMemOut);
    check_cnt("powerUpSeq", 1, nUp);
    tick(BEEP + 2);
    check_cnt("beepCount", 1, nBeepRise);
    check_cnt("beepLength", BEEP, nBeepCyc);
    check_bit("clrMemHeld", 1'b1, clearMemOut);
    press(0, DEB + 2);
    check_bit("clrPowerBtn", 1'b0, clearMemOut);
  endtask : t_clear_seq

  task automatic t_clear_cmd();
    clr_cmd(1'b0, 1'b0, 1'b0);
    check_bit("seqEnOff", 1'b0, clearSeqEnabled);
    run_seq(DEB + HOLD + 6);
    check_cnt("upDisabled", 0, nUp);
    clr_cmd(1'b1, 1'b1, 1'b0);
    check_bit("seqEnOn", 1'b1, clearSeqEnabled);
    check_bit("clrForceOn", 1'b1, clearMemOut);
    clr_cmd(1'b1, 1'b0, 1'b1);
    check_bit("clrForceOff", 1'b0, clearMemOut);
    clr_cmd(1'b1, 1'b1, 1'b0);
    press(2, DEB + 2);
    check_bit("clrResetBtn", 1'b0, clearMemOut);
    clr_cmd(1'b1, 1'b1, 1'b0);
    sysPwrOn = 1'b1;
    tick(6);
    check_bit("clrBoot", 1'b0, clearMemOut);
    run_seq(DEB + HOLD + 6);
    check_cnt("upPowerOn", 0, nUp);
    clr_cmd(1'b1, 1'b1, 1'b0);
    sysPwrOn = 1'b0;
    tick(6);
    check_bit("clrPowerOff", 1'b0, clearMemOut);
  endtask : t_clear_cmd

  task automatic t_secure();
    sysPwrOn = 1'b1;
    tick(6);
    sec_cfg(1'b1, 1'b0, 5'h00);
    kbcLockRequest = 1'b1;
    tick(4);
    check_bit("secureKbc", 1'b1, secureActive);
    for (int s = 0; s < 3; s++) begin
      sleepState = states[s];
      for (int b = 0; b < 5; b++) begin
        zero();
        press(b, DEB + 2);
        check_cnt("violation", int'(prot[s][b]), nViol);
        check_cnt("pressOut", int'(!prot[s][b]), nPress[b]);
      end
    end
    sleepState = fp_pkg::SLEEP_S1;
    zero();
    press(0, DEB + HOLD + 6);
    check_cnt("overrideS1", 0, nOvr);
    check_cnt("wakeS1", 1, nPress[0]);
    kbcLockRequest = 1'b0;
    sleepState = fp_pkg::SLEEP_S0;
    tick(4);
    zero();
    press(0, DEB + HOLD + 6);
    check_cnt("overrideOpen", 1, nOvr);
    check_cnt("violOpen", 0, nViol);
    sec_cfg(1'b1, 1'b1, 5'h08);
    check_bit("secureForce", 1'b1, secureActive);
    zero();
    press(3, DEB + 2);
    check_cnt("diagLocked", 1, nViol);
    check_cnt("diagLockedOut", 0, nPress[3]);
    sys_reset();
    check_bit("secureCleared", 1'b0, secureActive);
    zero();
    press(3, DEB + 2);
    check_cnt("diagUnlocked", 1, nPress[3]);
  endtask : t_secure

  task automatic t_faults();
    rpt(4'h3, 2'(fp_pkg::FAULT_TEMP), 1'b1);
    check_vec("ledsTemp", 8'h02, {4'h0, faultLeds});
    check_bit("fanBoostOn", 1'b1, fanBoost);
    rpt(4'h5, 2'(fp_pkg::FAULT_TEMP), 1'b1);
    rpt(4'h3, 2'(fp_pkg::FAULT_TEMP), 1'b0);
    check_vec("ledsOtherSrc", 8'h02, {4'h0, faultLeds});
    rpt(4'h5, 2'(fp_pkg::FAULT_TEMP), 1'b0);
    check_vec("ledsReplaced", 8'h00, {4'h0, faultLeds});
    check_bit("fanBoostOff", 1'b0, fanBoost);
    rpt(4'h9, 2'(fp_pkg::FAULT_DRIVE), 1'b1);
    platformFault = 4'h4;
    tick(4);
    check_vec("ledsMerged", 8'h0C, {4'h0, faultLeds});
    sys_reset();
    check_vec("ledsSysReset", 8'h04, {4'h0, faultLeds});
    platformFault = 4'h0;
    rpt(4'h1, 2'(fp_pkg::FAULT_FAN), 1'b1);
    sysPwrOn = 1'b0;
    tick(4);
    sysPwrOn = 1'b1;
    tick(6);
    check_vec("ledsPowerUp", 8'h00, {4'h0, faultLeds});
  endtask : t_faults

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0; rst_n = 1'b0; pressReq = 5'h00; cmdReq = 1'b0; cmdEnable = 1'b0;
    cmdForceOn = 1'b0; cmdForceOff = 1'b0; standbyPwr = 1'b1; sysPwrOn = 1'b0;
    sysResetIn = 1'b0; sleepState = fp_pkg::SLEEP_S45; kbcLockRequest = 1'b0;
    secOptValid = 1'b0; secOptEnable = 1'b0; secOptForceOn = 1'b0; secOptLockMask = 5'h00;
    faultValid = 1'b0; faultSource = 4'h0; faultType = 2'h0; faultState = 1'b0;
    platformFault = 4'h0;
    zero();
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(4);
    check_bit("seqEnReset", 1'b1, clearSeqEnabled);
    t_clear_seq();
    t_clear_cmd();
    t_secure();
    t_faults();
    check_vec("violOffset", 8'h00, violationOffset);
    report_and_stop();
  end

  // the tests need about 700 cycles; the 20000-cycle limit means a hang
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule : front_panel_clear_and_secure_ctrl_bench

// ==== test/panel_host_model.sv ====
/*
  Far-side model: front-panel buttons and host boot firmware clear-options commands.
  Assumes the bench raises requests just after a rising clock edge.
*/
`timescale 1ns/1ps
module panel_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench requests
  input wire logic [4:0] pressReq,
  input wire logic cmdReq,
  input wire logic cmdEnable,
  input wire logic cmdForceOn,
  input wire logic cmdForceOff,
  input wire logic sysPwrOn,
  // panel pins, pulled up, low while pressed
  output logic [4:0] btnN,
  // clear-options command
  output logic clrOptValid,
  output logic clrOptEnable,
  output logic clrOptForceOn,
  output logic clrOptForceOff
);
  logic pwrSeen_q;
  logic boot;

  assign btnN = ~pressReq;
  assign boot = sysPwrOn & !pwrSeen_q;

  always_ff @(posedge clk) begin
    pwrSeen_q <= sysPwrOn;
  end

  // firmware forces the clear state off on each boot so a clear never repeats
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clrOptValid <= 1'b0;
      clrOptEnable <= 1'b0;
      clrOptForceOn <= 1'b0;
      clrOptForceOff <= 1'b0;
    end else if (cmdReq) begin
      clrOptValid <= 1'b1;
      clrOptEnable <= cmdEnable;
      clrOptForceOn <= cmdForceOn;
      clrOptForceOff <= cmdForceOff;
    end else if (boot) begin
      clrOptValid <= 1'b1;
      clrOptEnable <= 1'b1;
      clrOptForceOn <= 1'b0;
      clrOptForceOff <= 1'b1;
    end else begin
      // fields mean nothing between strobes, so they keep moving
      clrOptValid <= 1'b0;
      clrOptEnable <= ~clrOptEnable;
      clrOptForceOn <= ~clrOptForceOn;
      clrOptForceOff <= ~clrOptForceOff;
    end
  end
endmodule : panel_host_model

// ==== verilog/button_debounce.sv ====
/*
  Synchroniser and debouncer for one active-low button pin.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module button_debounce #(
  parameter int unsigned STABLE_CYC = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and debounced level
  input wire logic pinN,
  output logic pressed
);
  logic syncA_q;
  logic syncB_q;
  logic [31:0] cnt_q;
  logic pressed_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
    end else begin
      syncA_q <= pinN;
      syncB_q <= syncA_q;
    end
  end

  // any high sample restarts the low-time count
  always_ff @(posedge clk) begin
    if (!rst_n || syncB_q) begin
      cnt_q <= '0;
      pressed_q <= 1'b0;
    end else if (cnt_q == 32'(STABLE_CYC - 1)) begin
      pressed_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'd1;
    end
  end

  assign pressed = pressed_q;
endmodule : button_debounce

// ==== verilog/fault_tracker.sv ====
/*
  Per-source fault store merged with the platform's own faults.
  Assumes report fields are on the clk domain.
*/
`timescale 1ns/1ps
module fault_tracker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clearAll,
  // fault report
  input wire logic rptValid,
  input wire logic [3:0] rptSource,
  input wire logic [1:0] rptType,
  input wire logic rptState,
  input wire logic [3:0] platformFault,
  // merged result
  output logic [3:0] faultLeds,
  output logic fanBoost
);
  logic [3:0] faultMem_q [fp_pkg::FAULT_SOURCES];
  logic [3:0] merged;
  logic [3:0] leds_q;
  logic boost_q;

  always_ff @(posedge clk) begin
    if (!rst_n || clearAll) begin
      for (int s = 0; s < fp_pkg::FAULT_SOURCES; s++) begin
        faultMem_q[s] <= '0;
      end
    end else if (rptValid) begin
      faultMem_q[rptSource][rptType] <= rptState;
    end
  end

  always_comb begin
    merged = platformFault;
    for (int s = 0; s < fp_pkg::FAULT_SOURCES; s++) begin
      merged = merged | faultMem_q[s];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      leds_q <= '0;
      boost_q <= 1'b0;
    end else begin
      leds_q <= merged;
      boost_q <= merged[fp_pkg::FAULT_FAN] | merged[fp_pkg::FAULT_TEMP];
    end
  end

  assign faultLeds = leds_q;
  assign fanBoost = boost_q;
endmodule : fault_tracker

// ==== verilog/front_panel_clear_and_secure_ctrl.sv ====
/*
  Front-panel clear-memory sequence, secure-mode button gating and fault merge.
  Assumes buttons and platform pins are asynchronous; commands are clk pulses.
*/
`timescale 1ns/1ps
module front_panel_clear_and_secure_ctrl #(
  parameter int unsigned DEBOUNCE_CYC = fp_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned HOLD_CYC = fp_pkg::HOLD_CYCLES,
  parameter int unsigned BEEP_CYC = fp_pkg::BEEP_CYCLES
) (
  // clock and controller reset
  input wire logic clk,
  input wire logic rst_n,
  // raw buttons, active low
  input wire logic powerBtnN,
  input wire logic sleepBtnN,
  input wire logic resetBtnN,
  input wire logic diagBtnN,
  input wire logic identBtnN,
  // platform pins
  input wire logic standbyPwr,
  input wire logic sysPwrOn,
  input wire logic sysResetIn,
  input wire logic [1:0] sleepState,
  input wire logic kbcLockRequest,
  // clear-options command
  input wire logic clrOptValid,
  input wire logic clrOptEnable,
  input wire logic clrOptForceOn,
  input wire logic clrOptForceOff,
  // secure-options command
  input wire logic secOptValid,
  input wire logic secOptEnable,
  input wire logic secOptForceOn,
  input wire logic [4:0] secOptLockMask,
  // fault-report command
  input wire logic faultValid,
  input wire logic [3:0] faultSource,
  input wire logic [1:0] faultType,
  input wire logic faultState,
  input wire logic [3:0] platformFault,
  // clear sequence results
  output logic clearMemOut,
  output logic beepOut,
  output logic powerUpReq,
  output logic clearSeqEnabled,
  // secure mode results
  output logic secureActive,
  output logic [4:0] btnPressOut,
  output logic powerOverrideOut,
  output logic violationEvt,
  output logic [7:0] violationOffset,
  // fault indication
  output logic [3:0] faultLeds,
  output logic fanBoost
);
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic standbyS;
  logic sysPwrS;
  logic sysRstS;
  logic [1:0] sleepS;
  logic kbcS;
  logic stbyPrev_q;
  logic pwrPrev_q;
  logic acRise;
  logic pwrRise;
  logic pwrFall;
  logic [4:0] btnRawN;
  logic [4:0] btnLvl;
  logic [4:0] btnPrev_q;
  logic [4:0] btnPress;
  logic [4:0] btnRelease;
  logic secEnable_q;
  logic secForce_q;
  logic [4:0] lockMask_q;
  logic secClear;
  logic secAct;
  logic [4:0] protectMask;
  logic ovrProtect;
  logic [4:0] blocked;
  logic [4:0] blockedPress;
  logic [31:0] ovrCnt_q;
  logic ovrFire;
  logic ovrBlocked;
  logic [4:0] pressOut_q;
  logic ovrOut_q;
  logic viol_q;
  logic [7:0] violOff_q;
  logic clrEnable_q;
  logic seqAllowed;
  fp_pkg::seq_state_e seqState_q;
  fp_pkg::seq_state_e seqState_d;
  logic seqDone;
  logic [31:0] seqCnt_q;
  logic clearMem_q;
  logic clrSet;
  logic clrEnd;
  logic powerUp_q;
  logic beep_q;
  logic [31:0] beepCnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {kbcLockRequest, sleepState, sysResetIn, sysPwrOn, standbyPwr};
      syncB_q <= syncA_q;
    end
  end

  assign standbyS = syncB_q[0];
  assign sysPwrS = syncB_q[1];
  assign sysRstS = syncB_q[2];
  assign sleepS = syncB_q[4:3];
  assign kbcS = syncB_q[5];

  assign btnRawN = {identBtnN, diagBtnN, resetBtnN, sleepBtnN, powerBtnN};

  for (genvar i = 0; i < fp_pkg::BTN_COUNT; i++) begin : g_deb
    button_debounce #(
      .STABLE_CYC(DEBOUNCE_CYC)
    ) u_deb (
      .clk(clk),
      .rst_n(rst_n),
      .pinN(btnRawN[i]),
      .pressed(btnLvl[i])
    );
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stbyPrev_q <= 1'b0;
      pwrPrev_q <= 1'b0;
      btnPrev_q <= '0;
    end else begin
      stbyPrev_q <= standbyS;
      pwrPrev_q <= sysPwrS;
      btnPrev_q <= btnLvl;
    end
  end

  assign acRise = standbyS & ~stbyPrev_q;
  assign pwrRise = sysPwrS & ~pwrPrev_q;
  assign pwrFall = ~sysPwrS & pwrPrev_q;
  assign btnPress = btnLvl & ~btnPrev_q;
  assign btnRelease = ~btnLvl & btnPrev_q;

  // secure configuration; a clear cause outranks a command in the same cycle
  assign secClear = sysRstS | acRise | pwrRise;

  always_ff @(posedge clk) begin
    if (!rst_n || secClear) begin
      secEnable_q <= 1'b0;
      secForce_q <= 1'b0;
      lockMask_q <= '0;
    end else if (secOptValid) begin
      secEnable_q <= secOptEnable;
      secForce_q <= secOptForceOn;
      lockMask_q <= secOptLockMask;
    end
  end

  assign secAct = secEnable_q & (secForce_q | kbcS);

  // diagnostic and identify bits are never set here
  always_comb begin
    protectMask = '0;
    ovrProtect = 1'b0;
    case (sleepS)
      fp_pkg::SLEEP_S0: begin
        protectMask[fp_pkg::BTN_POWER] = 1'b1;
        protectMask[fp_pkg::BTN_SLEEP] = 1'b1;
        protectMask[fp_pkg::BTN_RESET] = 1'b1;
        ovrProtect = 1'b1;
      end
      fp_pkg::SLEEP_S1: begin
        protectMask[fp_pkg::BTN_RESET] = 1'b1;
        ovrProtect = 1'b1;
      end
      default: begin
        protectMask = '0;
      end
    endcase
  end

  assign blocked = lockMask_q | ({5{secAct}} & protectMask);
  assign blockedPress = btnPress & blocked;
  assign ovrFire = btnLvl[fp_pkg::BTN_POWER] && ovrCnt_q == 32'(HOLD_CYC - 1);
  assign ovrBlocked = lockMask_q[fp_pkg::BTN_POWER] | (secAct & ovrProtect);

  // long power hold fires once per hold
  always_ff @(posedge clk) begin
    if (!rst_n || !btnLvl[fp_pkg::BTN_POWER]) begin
      ovrCnt_q <= '0;
    end else if (ovrCnt_q < 32'(HOLD_CYC)) begin
      ovrCnt_q <= ovrCnt_q + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pressOut_q <= '0;
      ovrOut_q <= 1'b0;
      viol_q <= 1'b0;
      violOff_q <= fp_pkg::VIOLATION_OFFSET;
    end else begin
      pressOut_q <= btnPress & ~blocked;
      ovrOut_q <= ovrFire & ~ovrBlocked;
      viol_q <= (|blockedPress) | (ovrFire & ovrBlocked);
      violOff_q <= fp_pkg::VIOLATION_OFFSET;
    end
  end

  // clear sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clrEnable_q <= fp_pkg::CLR_SEQ_EN_RST;
    end else if (clrOptValid) begin
      clrEnable_q <= clrOptEnable;
    end
  end

  assign seqAllowed = standbyS & ~sysPwrS & clrEnable_q;

  always_comb begin
    seqState_d = seqState_q;
    seqDone = 1'b0;
    if (!seqAllowed) begin
      seqState_d = fp_pkg::SEQ_IDLE;
    end else begin
      case (seqState_q)
        fp_pkg::SEQ_IDLE: begin
          if (btnLvl[fp_pkg::BTN_RESET]) begin
            seqState_d = fp_pkg::SEQ_HOLD;
          end
        end
        fp_pkg::SEQ_HOLD: begin
          if (!btnLvl[fp_pkg::BTN_RESET]) begin
            seqState_d = fp_pkg::SEQ_IDLE;
          end else if (seqCnt_q == 32'(HOLD_CYC - 1)) begin
            seqState_d = fp_pkg::SEQ_ARMED;
          end
        end
        fp_pkg::SEQ_ARMED: begin
          if (!btnLvl[fp_pkg::BTN_RESET]) begin
            seqState_d = fp_pkg::SEQ_IDLE;
          end else if (btnPress[fp_pkg::BTN_POWER]) begin
            // a power press that began before the hold qualified does not count
            seqState_d = fp_pkg::SEQ_RELEASE;
          end
        end
        fp_pkg::SEQ_RELEASE: begin
          if (!btnLvl[fp_pkg::BTN_RESET] && !btnLvl[fp_pkg::BTN_POWER]) begin
            seqState_d = fp_pkg::SEQ_IDLE;
            seqDone = 1'b1;
          end
        end
        default: begin
          seqState_d = fp_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seqState_q <= fp_pkg::SEQ_IDLE;
    end else begin
      seqState_q <= seqState_d;
    end
  end

  // the count only runs while the hold is unbroken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seqCnt_q <= '0;
    end else if (seqState_q == fp_pkg::SEQ_HOLD && seqState_d == fp_pkg::SEQ_HOLD) begin
      seqCnt_q <= seqCnt_q + 32'd1;
    end else begin
      seqCnt_q <= '0;
    end
  end

  // unbroken reset level, counted apart from the sequence for the hold check
  logic [31:0] rstHeld_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !btnLvl[fp_pkg::BTN_RESET]) begin
      rstHeld_q <= '0;
    end else if (rstHeld_q < 32'(HOLD_CYC)) begin
      rstHeld_q <= rstHeld_q + 32'd1;
    end
  end

  // clear state: a set in the same cycle as an end wins
  assign clrSet = seqDone | (clrOptValid & clrOptForceOn);
  assign clrEnd = (clrOptValid & clrOptForceOff) | btnPress[fp_pkg::BTN_RESET]
                | btnRelease[fp_pkg::BTN_POWER] | pwrFall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clearMem_q <= 1'b0;
    end else if (clrSet) begin
      clearMem_q <= 1'b1;
    end else if (clrEnd) begin
      clearMem_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powerUp_q <= 1'b0;
    end else begin
      powerUp_q <= seqDone;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      beep_q <= 1'b0;
      beepCnt_q <= '0;
    end else if (seqDone) begin
      beep_q <= 1'b1;
      beepCnt_q <= '0;
    end else if (beep_q) begin
      if (beepCnt_q == 32'(BEEP_CYC - 1)) begin
        beep_q <= 1'b0;
      end else begin
        beepCnt_q <= beepCnt_q + 32'd1;
      end
    end
  end

  fault_tracker u_fault (
    .clk(clk),
    .rst_n(rst_n),
    .clearAll(sysRstS | pwrRise),
    .rptValid(faultValid),
    .rptSource(faultSource),
    .rptType(faultType),
    .rptState(faultState),
    .platformFault(platformFault),
    .faultLeds(faultLeds),
    .fanBoost(fanBoost)
  );

  assign clearMemOut = clearMem_q;
  assign beepOut = beep_q;
  assign powerUpReq = powerUp_q;
  assign clearSeqEnabled = clrEnable_q;
  assign secureActive = secAct;
  assign btnPressOut = pressOut_q;
  assign powerOverrideOut = ovrOut_q;
  assign violationEvt = viol_q;
  assign violationOffset = violOff_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_SEQ_GATED:
    assert property (!seqAllowed |=> seqState_q == fp_pkg::SEQ_IDLE)
    else $error("sequence advanced while not allowed");
  AST_HOLD_MIN:
    assert property ((seqState_q == fp_pkg::SEQ_ARMED && btnLvl[fp_pkg::BTN_RESET])
                     |-> rstHeld_q >= 32'(HOLD_CYC))
    else $error("hold qualified early");
  AST_DONE_EFFECT:
    assert property (seqDone |=> clearMem_q && powerUp_q && beep_q)
    else $error("completion effects missing");
  AST_ONE_BEEP:
    assert property ($rose(beep_q) |-> $past(seqDone))
    else $error("beep without completion");
  AST_ENABLE_BIT:
    assert property (!clrEnable_q |-> !seqDone)
    else $error("sequence completed while disabled");
  AST_FORCE_ON:
    assert property (clrOptValid && clrOptForceOn |=> clearMemOut)
    else $error("command did not enter clear state");
  AST_CLEAR_END:
    assert property (clrEnd && !clrSet |=> !clearMemOut)
    else $error("clear state not ended");
  AST_SECURE_KBC:
    assert property (secEnable_q && !secForce_q |-> secureActive == kbcS)
    else $error("secure not following keyboard line");
  AST_SUPPRESS:
    assert property (blockedPress != '0 |=> violationEvt && (btnPressOut & $past(blockedPress)) == '0)
    else $error("protected press not suppressed");
  AST_SECURE_CLEAR:
    assert property (secClear |=> !secEnable_q && !secForce_q && lockMask_q == '0)
    else $error("secure state survived clear");
  AST_S45_FREE:
    assert property (sleepS == fp_pkg::SLEEP_S45 && btnPress[fp_pkg::BTN_POWER]
                     && !lockMask_q[fp_pkg::BTN_POWER] |=> btnPressOut[fp_pkg::BTN_POWER])
    else $error("power blocked in soft off");
  AST_S1_OVERRIDE:
    assert property (secAct && sleepS == fp_pkg::SLEEP_S1 && ovrFire |=> !powerOverrideOut)
    else $error("override passed in S1");
  AST_DIAG_FREE:
    assert property (btnPress[fp_pkg::BTN_DIAG] && !lockMask_q[fp_pkg::BTN_DIAG]
                     |=> btnPressOut[fp_pkg::BTN_DIAG])
    else $error("diagnostic press blocked");
  AST_HOLD_RESTART:
    assert property (seqState_q == fp_pkg::SEQ_HOLD && !btnLvl[fp_pkg::BTN_RESET]
                     |=> seqCnt_q == '0 && seqState_q == fp_pkg::SEQ_IDLE)
    else $error("hold timer not restarted");

  COV_SEQ_DONE: cover property (seqDone);
  COV_VIOLATION: cover property (violationEvt);
  COV_REMOTE_CLEAR: cover property (clrOptValid && clrOptForceOn);
  COV_OVERRIDE: cover property (powerOverrideOut);
endmodule : front_panel_clear_and_secure_ctrl
